// ===== src/vsl_pkg.sv
// Package with register map, field layouts and decoded control types.
package vsl_pkg;
    localparam logic [7:0] SYNC_CONTROL_ADDR = 8'h08;
    localparam logic [7:0] LUMA_FILTER_ADDR = 8'h09;
    localparam logic [7:0] BRIGHTNESS_ADDR = 8'h0A;
    localparam logic [7:0] SYNC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] LUMA_FILTER_RESET = 8'h00;
    localparam logic [7:0] BRIGHTNESS_RESET = 8'h80;
    localparam int AUTO_FIELD_DETECT_BIT = 7;
    localparam int FIELD_RATE_SELECT_BIT = 6;
    localparam int FORCED_FIELD_FLAG_TOGGLE_BIT = 5;
    localparam int HTC_LSB = 3;
    localparam int LINE_LOCK_LOOP_OPEN_BIT = 2;
    localparam int VNOI_LSB = 0;
    localparam int TRAP_COMB_BYPASS_BIT = 7;
    localparam int COMB_BIT = 6;
    localparam int EXTRA_LINE_DELAY_BIT = 5;
    localparam int REMOD_BANDWIDTH_WIDE_BIT = 4;
    localparam int SHARP_LSB = 0;
    localparam logic [1:0] LINES_NTSC = 2'h1;
    localparam logic [1:0] LINES_PAL = 2'h2;
    localparam logic [3:0] SHARP_LOWPASS_MIN = 4'h8;

    typedef enum logic [1:0] {HTC_TV, HTC_VTR, HTC_RESERVED, HTC_FAST} htc_t;
    typedef enum logic [1:0] {VN_NORMAL, VN_FAST, VN_FREE, VN_BYPASS} vnoise_t;
    typedef enum logic [1:0] {LF_TRAP, LF_COMB, LF_BYPASS} luma_filter_t;
    typedef enum logic [1:0] {SH_PLAIN, SH_ENHANCE, SH_LOWPASS} sharp_kind_t;

    typedef struct packed {
        logic field_60hz;
        logic field_flag;
        htc_t time_constant;
        logic loop_open;
        vnoise_t noise_mode;
    } sync_out_t;

    typedef struct packed {
        luma_filter_t filter;
        logic [1:0] extra_lines;
        logic wide_notch;
        sharp_kind_t sharp_kind;
        logic [3:0] sharp_code;
        logic [7:0] brightness;
    } luma_out_t;
endpackage

// ===== src/video_sync_luma_control.sv
// Sync and luminance control register group of a video decoder.
`timescale 1ns/1ns
// Function
// - With auto detection off, field-rate select 0 gives 50 Hz/625 lines, 1 gives 60 Hz/525.
// - Sync control bit 7 set makes the field standard follow the detected input standard.
// - Forced toggle clear lets the field flag toggle only on interlaced sources.
// - Forced toggle set toggles the field flag on every field.
// - Bits 4:3 pick TV, VTR, reserved or fast-locking horizontal time constant.
// - Bit 2 clear closes the line-lock loop; set opens it with fixed frequency.
// - Bits 1:0 pick normal, fast, free-running or bypassed vertical noise reduction.
// - Luma bit 7 clear keeps the trap or comb active; set bypasses them.
// - Without bypass, bit 6 set selects the adaptive comb and clear the chroma trap.
// - In non-comb mode bit 5 adds one line of delay for NTSC and two for PAL.
// - Bit 4 clear gives a narrow notch, set a wide notch with lower luma bandwidth.
// - Sharpness 0000 is plain and 0001 to 0111 are enhancement responses.
// - Sharpness 1000 to 1111 are low-pass responses of rising strength.
// - The eight-bit unsigned brightness offset is passed on as written.
module video_sync_luma_control
(
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [7:0] SUBADDR,
    input wire logic [7:0] WR_DATA,
    output logic [7:0] RD_DATA,
    input wire logic DETECTED_60HZ,
    input wire logic SOURCE_INTERLACED,
    input wire logic FIELD_START,
    output vsl_pkg::sync_out_t SYNC_OUT,
    output vsl_pkg::luma_out_t LUMA_OUT
);
    import vsl_pkg::*;

    function automatic sharp_kind_t sharp_kind(input logic [3:0] code);
        if (code == 4'h0)
            sharp_kind = SH_PLAIN;
        else if (code < SHARP_LOWPASS_MIN)
            sharp_kind = SH_ENHANCE;
        else
            sharp_kind = SH_LOWPASS;
    endfunction

    logic [7:0] sync_control;
    logic [7:0] luma_filter_control;
    logic [7:0] luma_brightness_offset;
    logic [7:0] next_sync_control;
    logic [7:0] next_luma_filter_control;
    logic [7:0] next_luma_brightness_offset;
    logic [7:0] next_rd_data;
    sync_out_t next_sync_out;
    luma_out_t next_luma_out;
    logic field_flag;
    logic next_field_flag;
    logic auto_field_detect;
    logic forced_field_flag_toggle;
    logic trap_comb_bypass;
    logic adaptive_luma_comb_enable;
    logic extra_line_delay;
    logic field_is_60;
    logic [3:0] sharpness_select;

    always_comb
    begin
        next_sync_control = sync_control;
        next_luma_filter_control = luma_filter_control;
        next_luma_brightness_offset = luma_brightness_offset;
        next_rd_data = RD_DATA;
        if (WR_EN)
        begin
            case (SUBADDR)
                SYNC_CONTROL_ADDR: next_sync_control = WR_DATA;
                LUMA_FILTER_ADDR: next_luma_filter_control = WR_DATA;
                BRIGHTNESS_ADDR: next_luma_brightness_offset = WR_DATA;
                default: ;
            endcase
        end
        if (RD_EN)
        begin
            case (SUBADDR)
                SYNC_CONTROL_ADDR: next_rd_data = sync_control;
                LUMA_FILTER_ADDR: next_rd_data = luma_filter_control;
                BRIGHTNESS_ADDR: next_rd_data = luma_brightness_offset;
                default: next_rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            sync_control <= SYNC_CONTROL_RESET;
            luma_filter_control <= LUMA_FILTER_RESET;
            luma_brightness_offset <= BRIGHTNESS_RESET;
            RD_DATA <= 8'h00;
        end
        else
        begin
            sync_control <= next_sync_control;
            luma_filter_control <= next_luma_filter_control;
            luma_brightness_offset <= next_luma_brightness_offset;
            RD_DATA <= next_rd_data;
        end
    end

    assign auto_field_detect = sync_control[AUTO_FIELD_DETECT_BIT];
    assign forced_field_flag_toggle = sync_control[FORCED_FIELD_FLAG_TOGGLE_BIT];
    assign trap_comb_bypass = luma_filter_control[TRAP_COMB_BYPASS_BIT];
    assign adaptive_luma_comb_enable = luma_filter_control[COMB_BIT];
    assign extra_line_delay = luma_filter_control[EXTRA_LINE_DELAY_BIT];
    assign sharpness_select = luma_filter_control[SHARP_LSB +: 4];
    // Detected or forced field standard.
    assign field_is_60 = auto_field_detect ? DETECTED_60HZ
                                           : sync_control[FIELD_RATE_SELECT_BIT];

    always_comb
    begin
        next_field_flag = field_flag;
        if (FIELD_START && (forced_field_flag_toggle || SOURCE_INTERLACED))
            next_field_flag = ~field_flag;

        next_sync_out.field_60hz = field_is_60;
        next_sync_out.field_flag = next_field_flag;
        next_sync_out.time_constant = htc_t'(sync_control[HTC_LSB +: 2]);
        next_sync_out.loop_open = sync_control[LINE_LOCK_LOOP_OPEN_BIT];
        next_sync_out.noise_mode = vnoise_t'(sync_control[VNOI_LSB +: 2]);

        if (trap_comb_bypass)
            next_luma_out.filter = LF_BYPASS;
        else if (adaptive_luma_comb_enable)
            next_luma_out.filter = LF_COMB;
        else
            next_luma_out.filter = LF_TRAP;
        next_luma_out.extra_lines = 2'h0;
        if (extra_line_delay && (trap_comb_bypass || !adaptive_luma_comb_enable))
            next_luma_out.extra_lines = field_is_60 ? LINES_NTSC : LINES_PAL;
        next_luma_out.wide_notch = luma_filter_control[REMOD_BANDWIDTH_WIDE_BIT];
        next_luma_out.sharp_kind = sharp_kind(sharpness_select);
        next_luma_out.sharp_code = sharpness_select;
        next_luma_out.brightness = luma_brightness_offset;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            field_flag <= 1'b0;
            SYNC_OUT <= '0;
            LUMA_OUT <= '0;
        end
        else
        begin
            field_flag <= next_field_flag;
            SYNC_OUT <= next_sync_out;
            LUMA_OUT <= next_luma_out;
        end
    end

    a_field_select: assert property (@(posedge REF_CLK) disable iff (RESET)
        !auto_field_detect |=> SYNC_OUT.field_60hz == $past(sync_control[FIELD_RATE_SELECT_BIT]))
        else $error("Forced field standard not applied.");

    a_field_auto: assert property (@(posedge REF_CLK) disable iff (RESET)
        auto_field_detect |=> SYNC_OUT.field_60hz == $past(DETECTED_60HZ))
        else $error("Detected field standard not applied.");

    a_flag_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
        FIELD_START && !forced_field_flag_toggle && !SOURCE_INTERLACED
        |=> $stable(field_flag))
        else $error("Field flag toggled on progressive source.");

    sequence field_toggle_s;
        FIELD_START && (forced_field_flag_toggle || SOURCE_INTERLACED);
    endsequence

    a_flag_toggle: assert property (@(posedge REF_CLK) disable iff (RESET)
        field_toggle_s |=> field_flag != $past(field_flag) ##0 SYNC_OUT.field_flag == field_flag)
        else $error("Field flag did not toggle.");

    a_htc_map: assert property (@(posedge REF_CLK) disable iff (RESET)
        1'b1 |=> SYNC_OUT.time_constant == htc_t'($past(sync_control[HTC_LSB +: 2])))
        else $error("Time constant mismatch.");

    a_loop_open: assert property (@(posedge REF_CLK) disable iff (RESET)
        sync_control[LINE_LOCK_LOOP_OPEN_BIT] |=> SYNC_OUT.loop_open)
        else $error("Line-lock loop not opened.");

    a_noise_mode: assert property (@(posedge REF_CLK) disable iff (RESET)
        sync_control[VNOI_LSB +: 2] == 2'h3 |=> SYNC_OUT.noise_mode == VN_BYPASS)
        else $error("Noise bypass not applied.");

    a_bypass: assert property (@(posedge REF_CLK) disable iff (RESET)
        trap_comb_bypass |=> LUMA_OUT.filter == LF_BYPASS)
        else $error("Trap and comb not bypassed.");

    a_comb_select: assert property (@(posedge REF_CLK) disable iff (RESET)
        !trap_comb_bypass |=> LUMA_OUT.filter == ($past(adaptive_luma_comb_enable) ? LF_COMB : LF_TRAP))
        else $error("Comb or trap selection wrong.");

    a_pal_delay: assert property (@(posedge REF_CLK) disable iff (RESET)
        extra_line_delay && trap_comb_bypass && !field_is_60 |=> LUMA_OUT.extra_lines == LINES_PAL)
        else $error("PAL extra delay wrong.");

    a_notch: assert property (@(posedge REF_CLK) disable iff (RESET)
        1'b1 |=> LUMA_OUT.wide_notch == $past(luma_filter_control[REMOD_BANDWIDTH_WIDE_BIT]))
        else $error("Notch width mismatch.");

    a_sharp_low: assert property (@(posedge REF_CLK) disable iff (RESET)
        sharpness_select[3] |=> LUMA_OUT.sharp_kind == SH_LOWPASS)
        else $error("Low-pass kind not selected.");

    a_sharp_enh: assert property (@(posedge REF_CLK) disable iff (RESET)
        !sharpness_select[3] && sharpness_select != 4'h0 |=> LUMA_OUT.sharp_kind == SH_ENHANCE)
        else $error("Enhancement kind not selected.");

    a_bright_write: assert property (@(posedge REF_CLK) disable iff (RESET)
        WR_EN && SUBADDR == BRIGHTNESS_ADDR ##1 !WR_EN |=> LUMA_OUT.brightness == $past(WR_DATA, 2))
        else $error("Brightness write not applied.");

    a_write_isolated: assert property (@(posedge REF_CLK) disable iff (RESET)
        WR_EN && SUBADDR != SYNC_CONTROL_ADDR |=> $stable(sync_control))
        else $error("Sync control disturbed by other write.");
endmodule

// ===== test/host_ctrl_model.sv
// Host model that programs the decoder subaddresses through the control strobes.
`timescale 1ns/1ns
module host_ctrl_model
(
    input wire logic clk,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] subaddr,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data
);
    initial
    begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        subaddr = 8'h00;
        wr_data = 8'h00;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        subaddr = a;
        // Fast noise mode goes out only with automatic detection off.
        wr_data = (a == 8'h08 && d[1:0] == 2'h1) ? (d & 8'h7F) : d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        wr_data = ~wr_data;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        subaddr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        d = rd_data;
    endtask
endmodule

// ===== test/video_sync_luma_control_tb.sv
// Self-checking testbench for the sync and luminance control registers.
`timescale 1ns/1ns
module video_sync_luma_control_tb;
    import vsl_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic wr_en, rd_en;
    logic [7:0] subaddr, wr_data, rd_data;
    logic det_60 = 1'b0;
    logic interlaced = 1'b0;
    logic field_start = 1'b0;
    sync_out_t sync_out;
    luma_out_t luma_out;
    logic [7:0] sreg = 8'h00, lreg = 8'h00, breg = 8'h80;
    logic ff = 1'b0;
    int fails = 0;
    int total_checks = 0;
    logic [7:0] sync_vals [12] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h08, 8'h10, 8'h18,
        8'h04, 8'h01, 8'h02, 8'h03, 8'hBF};
    logic [7:0] bright_vals [4] = '{8'h00, 8'hFF, 8'h80, 8'h5A};

    always #5 ref_clk = ~ref_clk;

    host_ctrl_model host (.clk(ref_clk), .wr_en(wr_en), .rd_en(rd_en), .subaddr(subaddr),
        .wr_data(wr_data), .rd_data(rd_data));

    video_sync_luma_control dut (.REF_CLK(ref_clk), .RESET(reset), .WR_EN(wr_en),
        .RD_EN(rd_en), .SUBADDR(subaddr), .WR_DATA(wr_data), .RD_DATA(rd_data),
        .DETECTED_60HZ(det_60), .SOURCE_INTERLACED(interlaced), .FIELD_START(field_start),
        .SYNC_OUT(sync_out), .LUMA_OUT(luma_out));

    function automatic logic f60();
        return sreg[AUTO_FIELD_DETECT_BIT] ? det_60 : sreg[FIELD_RATE_SELECT_BIT];
    endfunction

    function automatic luma_out_t exp_luma(input logic [7:0] l, input logic [7:0] b);
        logic [1:0] filt;
        logic [1:0] kind;
        filt = l[TRAP_COMB_BYPASS_BIT] ? 2'h2 : {1'b0, l[COMB_BIT]};
        kind = (l[3:0] == 4'h0) ? 2'h0 : (l[3] ? 2'h2 : 2'h1);
        return {filt, (l[EXTRA_LINE_DELAY_BIT] && filt != 2'h1) ? (f60() ? 2'h1 : 2'h2) : 2'h0,
            l[REMOD_BANDWIDTH_WIDE_BIT], kind, l[3:0], b};
    endfunction

    task automatic compare(input string what, input logic [18:0] e, input logic [18:0] g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %0h seen %0h", what, e, g);
        end
    endtask

    task automatic check_outs();
        @(negedge ref_clk);
        compare("sync_out", 19'({f60(), ff, sreg[4:0]}), 19'(sync_out));
        compare("luma_out", exp_luma(lreg, breg), luma_out);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write_reg(a, d);
        if (a == SYNC_CONTROL_ADDR)
            sreg = d;
        if (a == LUMA_FILTER_ADDR)
            lreg = d;
        if (a == BRIGHTNESS_ADDR)
            breg = d;
        check_outs();
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.read_reg(a, d);
        compare("rd_data", 19'(e), 19'(d));
    endtask

    task automatic field(input logic il);
        @(negedge ref_clk);
        interlaced = il;
        field_start = 1'b1;
        if (sreg[FORCED_FIELD_FLAG_TOGGLE_BIT] || il)
            ff = ~ff;
        @(negedge ref_clk);
        field_start = 1'b0;
        check_outs();
    endtask

    task automatic regs_at_reset();
        check_outs();
        rd_chk(SYNC_CONTROL_ADDR, 8'h00);
        rd_chk(LUMA_FILTER_ADDR, 8'h00);
        rd_chk(BRIGHTNESS_ADDR, 8'h80);
    endtask

    task automatic complete_run();
        if (fails == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(negedge ref_clk);
        reset = 1'b0;
        regs_at_reset();
        foreach (sync_vals[i])
        begin
            det_60 = i[0];
            wr(SYNC_CONTROL_ADDR, sync_vals[i]);
            rd_chk(SYNC_CONTROL_ADDR, sync_vals[i]);
        end
        for (int j = 0; j < 2; j++)
        begin
            wr(SYNC_CONTROL_ADDR, j[0] ? 8'h40 : 8'h00);
            for (int i = 0; i < 16; i++)
            begin
                wr(LUMA_FILTER_ADDR, {i[2:0], i[3], i[3:0]});
                rd_chk(LUMA_FILTER_ADDR, {i[2:0], i[3], i[3:0]});
            end
        end
        foreach (bright_vals[i])
        begin
            wr(BRIGHTNESS_ADDR, bright_vals[i]);
            rd_chk(BRIGHTNESS_ADDR, bright_vals[i]);
        end
        wr(8'h0B, 8'h33);
        rd_chk(8'h0B, 8'h00);
        rd_chk(SYNC_CONTROL_ADDR, sreg);
        wr(SYNC_CONTROL_ADDR, 8'h00);
        field(1'b0);
        field(1'b1);
        wr(SYNC_CONTROL_ADDR, 8'h20);
        field(1'b0);
        field(1'b1);
        @(negedge ref_clk);
        reset = 1'b1;
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        sreg = 8'h00;
        lreg = 8'h00;
        breg = 8'h80;
        ff = 1'b0;
        regs_at_reset();
        complete_run();
    end

    initial
    begin
        #50000;
        fails++;
        complete_run();
    end
endmodule
